// ### slbt_top.sv
// Loopback bit-error tester: APB registers, run control, channel muxing.
// Assumes APB master in the same clock; lanes are word-parallel streams.
//
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "slbt_consts.svh"

// Behaviour
// - PRBS of order 7, 15, 23 and 31 selectable as test data.
// - High frequency pattern alternates one and zero every bit.
// - Low frequency pattern is a square wave of thirty-three bit period.
// - A lane is synced once a received word matches the expected pattern word.
// - The PLL lock of each lane of the selected port is reported while a test runs.
// - Per channel status: lock, sync and error count for active port.
// - Once a lane is synced, received words differing from expected data count as detected errors.
// - A separate counter holds the number of injected errors.
// - Each insert accepted while none is pending corrupts exactly one word of channel 0 and adds one injected error.
// - Insert requests only take effect while a run is active.
// - Clear zeroes both the detected and the injected error counters.
// - Start begins transmission and checking on the selected port.
// - Stop ends transmission and checking and freezes statistics.
// - Port choice includes two optical ports of four lanes each.
// - A sixteen lane PCIe variant reports channels 0 through 15.
// - Per channel serial loopback returns a lane's transmit to its receive.
// - Transmit and receive throughput measured for percentage reporting.
module slbt_top #(
    parameter int CW = 32
) (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic [`SLBT_NLANE-1:0] pll_lock_in,
    input wire logic [`SLBT_NLANE-1:0] tx_ready_in,
    output logic [`SLBT_NLANE*`SLBT_DW-1:0] tx_data_out,
    input wire logic [`SLBT_NLANE-1:0] rx_valid_in,
    input wire logic [`SLBT_NLANE*`SLBT_DW-1:0] rx_data_in,
    output logic [`SLBT_NLANE-1:0] serial_loopback_out
);
    import slbt_pkg::*;

    localparam int NL = `SLBT_NLANE;
    localparam int NS = `SLBT_NSLOT;
    localparam int DW = `SLBT_DW;

    // =============================================================
    // Helper functions

    // Physical lane that a channel slot of the chosen port drives
    function automatic logic [4:0] slot_lane(slbt_port_t p,
        logic [4:0] c);
        case (p)
            optical_port_one: return `SLBT_OPT1_BASE + c;
            pcie_x16: return `SLBT_PCIE_BASE + c;
            default: return c;
        endcase
    endfunction

    // Slot in use for the chosen port
    function automatic logic slot_used(slbt_port_t p, logic [4:0] c);
        return c < ((p == pcie_x16) ? `SLBT_PCIE_LANES : `SLBT_OPT_LANES);
    endfunction

    // Counter step; an increment in the clearing cycle is kept
    function automatic logic [CW-1:0] bump(logic [CW-1:0] q, logic clr,
        logic [4:0] inc);
        return (clr ? '0 : q) + CW'(inc);
    endfunction

    // Mapped register offsets
    function automatic logic apb_hit(logic [7:0] a);
        case (a)
            `SLBT_A_CTRL, `SLBT_A_CMD, `SLBT_A_STATUS, `SLBT_A_LOOP,
            `SLBT_A_LOCK, `SLBT_A_SYNC, `SLBT_A_DET, `SLBT_A_INJ,
            `SLBT_A_CHSEL, `SLBT_A_CHERR, `SLBT_A_CYC, `SLBT_A_TXW,
            `SLBT_A_RXW: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    // =============================================================
    // Declarations
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic [31:0] rd_d;
    logic setup;
    logic acc;
    logic wr;
    slbt_port_t port_q;
    slbt_pat_t pat_q;
    logic [15:0] loop_q;
    logic [3:0] chsel_q;
    slbt_run_t state_q;
    logic restart_q;
    logic running;
    logic c_start;
    logic c_stop;
    logic c_ins;
    logic c_clr;
    logic ins_ok;
    logic pend0;
    logic [CW-1:0] det_q;
    logic [CW-1:0] inj_q;
    logic [CW-1:0] cyc_q;
    logic [CW-1:0] txw_q;
    logic [CW-1:0] rxw_q;
    logic [CW-1:0] cherr_q [NS];
    logic [NS-1:0] lock_q;
    logic [NS-1:0] sync_s;
    logic [NS-1:0] err_s;
    logic [NS-1:0] adv_s;
    logic [NS-1:0] vld_s;
    logic [NS-1:0] used_s;
    logic [DW-1:0] word_s [NS];
    logic [4:0] lane_s [NS];
    logic [DW-1:0] tx_d [NL];
    logic [NL-1:0] lb_d;
    logic [NL*DW-1:0] tx_q;
    logic [NL-1:0] lb_q;
    logic [4:0] err_cnt;
    logic all_lock;
    logic all_sync;

    // =============================================================
    // Channel slots: one generator and one checker each
    for (genvar g = 0; g < NS; g++) begin : g_slot
        slbt_lane_if lif();

        assign lane_s[g] = slot_lane(port_q, 5'(g));
        assign used_s[g] = slot_used(port_q, 5'(g));
        assign lif.run = running & used_s[g];
        assign lif.restart = restart_q;
        assign lif.pat = pat_q;
        assign lif.tx_adv = tx_ready_in[lane_s[g]];
        assign lif.inject = ins_ok & (g == 0);
        // Internal loopback feeds the checker with its own transmit word
        assign lif.rx_vld = loop_q[g] ? lif.tx_adv
            : rx_valid_in[lane_s[g]];
        assign lif.rx_word = loop_q[g] ? lif.tx_word
            : rx_data_in[int'(lane_s[g])*DW +: DW];
        assign word_s[g] = lif.tx_word;
        assign sync_s[g] = lif.synced;
        assign err_s[g] = lif.err;
        assign adv_s[g] = lif.tx_adv;
        assign vld_s[g] = lif.rx_vld;
        if (g == 0) begin : g_first
            assign pend0 = lif.inj_pend;
        end

        slbt_gen u_gen (
            .mclk_in(mclk_in),
            .rst_n_in(rst_n_in),
            .lane(lif.gen)
        );
        slbt_chk u_chk (
            .mclk_in(mclk_in),
            .rst_n_in(rst_n_in),
            .lane(lif.chk)
        );
    end

    // =============================================================
    // APB slave: one access cycle, no wait states
    assign setup = psel_in & ~penable_in;
    assign acc = psel_in & penable_in & pready_q;
    assign wr = acc & pwrite_in;

    // Ready and error are raised for the access phase only
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= setup;
            pslverr_q <= setup & ~apb_hit(paddr_in);
        end
    end

    // Read data captured in the setup cycle, zero otherwise
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            prdata_q <= '0;
        end else begin
            prdata_q <= (setup && !pwrite_in) ? rd_d : '0;
        end
    end

    assign all_lock = &(lock_q | ~used_s);
    assign all_sync = &(sync_s | ~used_s);

    // Read multiplexer; the command register reads as zero
    always_comb begin
        case (paddr_in)
            `SLBT_A_CTRL: rd_d = {27'd0, pat_q, port_q};
            `SLBT_A_STATUS: rd_d = {29'd0, all_sync, all_lock, running};
            `SLBT_A_LOOP: rd_d = {16'd0, loop_q};
            `SLBT_A_LOCK: rd_d = {16'd0, lock_q};
            `SLBT_A_SYNC: rd_d = {16'd0, sync_s};
            `SLBT_A_DET: rd_d = 32'(det_q);
            `SLBT_A_INJ: rd_d = 32'(inj_q);
            `SLBT_A_CHSEL: rd_d = {28'd0, chsel_q};
            `SLBT_A_CHERR: rd_d = 32'(cherr_q[chsel_q]);
            `SLBT_A_CYC: rd_d = 32'(cyc_q);
            `SLBT_A_TXW: rd_d = 32'(txw_q);
            `SLBT_A_RXW: rd_d = 32'(rxw_q);
            default: rd_d = 32'h0000_0000;
        endcase
    end

    // =============================================================
    // Writable settings
    // Port and pattern are locked while running, so a run never
    // changes lanes or sequence halfway through.
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            port_q <= optical_port_zero;
            pat_q <= pat_prbs7;
        end else if (wr && paddr_in == `SLBT_A_CTRL && !running) begin
            port_q <= slbt_port_t'(pwdata_in[`SLBT_CTRL_PORT_LSB +: 2]);
            pat_q <= slbt_pat_t'(pwdata_in[`SLBT_CTRL_PAT_LSB +: 3]);
        end
    end

    // Loopback enables and status channel select
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            loop_q <= `SLBT_LOOP_RST;
            chsel_q <= `SLBT_CHSEL_RST;
        end else if (wr && paddr_in == `SLBT_A_LOOP) begin
            loop_q <= pwdata_in[15:0];
        end else if (wr && paddr_in == `SLBT_A_CHSEL) begin
            chsel_q <= pwdata_in[3:0];
        end
    end

    // =============================================================
    // Commands and run control
    assign c_start = wr & (paddr_in == `SLBT_A_CMD)
        & pwdata_in[`SLBT_CMD_START];
    assign c_stop = wr & (paddr_in == `SLBT_A_CMD)
        & pwdata_in[`SLBT_CMD_STOP];
    assign c_ins = wr & (paddr_in == `SLBT_A_CMD)
        & pwdata_in[`SLBT_CMD_INSERT];
    assign c_clr = wr & (paddr_in == `SLBT_A_CMD)
        & pwdata_in[`SLBT_CMD_CLEAR];
    assign running = (state_q == st_run);
    // A second insert is dropped until the first has gone out
    assign ins_ok = c_ins & running & ~pend0;

    // Run state; stop wins over a start in the same write
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_q <= st_idle;
        end else begin
            case (state_q)
                st_idle: begin
                    if (c_start && !c_stop) begin
                        state_q <= st_run;
                    end
                end
                st_run: begin
                    if (c_stop) begin
                        state_q <= st_idle;
                    end
                end
                default: state_q <= st_idle;
            endcase
        end
    end

    // Start pulse reseeds generators and drops sync
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            restart_q <= 1'b0;
        end else begin
            restart_q <= c_start & ~c_stop;
        end
    end

    // =============================================================
    // Error statistics
    always_comb begin
        err_cnt = 5'd0;
        for (int i = 0; i < NS; i++) begin
            err_cnt = err_cnt + 5'(err_s[i]);
        end
    end

    // Detected and injected totals; frozen when stopped
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            det_q <= '0;
            inj_q <= '0;
        end else begin
            det_q <= bump(det_q, c_clr, err_cnt);
            inj_q <= bump(inj_q, c_clr, {4'd0, ins_ok});
        end
    end

    // Per channel error counts
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < NS; i++) begin
                cherr_q[i] <= '0;
            end
        end else begin
            for (int i = 0; i < NS; i++) begin
                cherr_q[i] <= bump(cherr_q[i], c_clr, {4'd0, err_s[i]});
            end
        end
    end

    // Throughput: run cycles, words sent and received on channel 0
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cyc_q <= '0;
            txw_q <= '0;
            rxw_q <= '0;
        end else begin
            cyc_q <= bump(cyc_q, restart_q, {4'd0, running});
            txw_q <= bump(txw_q, restart_q, {4'd0, running & adv_s[0]});
            rxw_q <= bump(rxw_q, restart_q, {4'd0, running & vld_s[0]});
        end
    end

    // Lock sampled per slot; unused slots read unlocked
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            lock_q <= '0;
        end else begin
            for (int i = 0; i < NS; i++) begin
                lock_q[i] <= used_s[i] & pll_lock_in[lane_s[i]];
            end
        end
    end

    // =============================================================
    // Lane outputs: slots steered onto the port's physical lanes
    always_comb begin
        lb_d = '0;
        for (int l = 0; l < NL; l++) begin
            tx_d[l] = '0;
        end
        for (int i = 0; i < NS; i++) begin
            if (used_s[i]) begin
                tx_d[lane_s[i]] = running ? word_s[i] : '0;
                lb_d[lane_s[i]] = loop_q[i];
            end
        end
    end

    // Registered lane drive
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tx_q <= '0;
            lb_q <= '0;
        end else begin
            for (int l = 0; l < NL; l++) begin
                tx_q[l*DW +: DW] <= tx_d[l];
            end
            lb_q <= lb_d;
        end
    end

    assign tx_data_out = tx_q;
    assign serial_loopback_out = lb_q;
    assign prdata_out = prdata_q;
    assign pready_out = pready_q;
    assign pslverr_out = pslverr_q;
endmodule

`default_nettype wire

// ### slbt_consts.svh
// Offsets, field positions, reset values and sizes of the lane tester.
// Included by bare name from the package, interface and design files.
`ifndef SLBT_CONSTS_SVH
`define SLBT_CONSTS_SVH

// =============================================================
// Sizes
`define SLBT_DW 32
`define SLBT_NLANE 24
`define SLBT_NSLOT 16
`define SLBT_OPT_LANES 5'd4
`define SLBT_PCIE_LANES 5'd16
`define SLBT_OPT1_BASE 5'd4
`define SLBT_PCIE_BASE 5'd8

// =============================================================
// Pattern constants
`define SLBT_SEED 31'h7fffffff
`define SLBT_LF_HIGH 6'd17
`define SLBT_LF_LAST 6'd32

// =============================================================
// Register byte offsets
`define SLBT_A_CTRL 8'h00
`define SLBT_A_CMD 8'h04
`define SLBT_A_STATUS 8'h08
`define SLBT_A_LOOP 8'h0c
`define SLBT_A_LOCK 8'h10
`define SLBT_A_SYNC 8'h14
`define SLBT_A_DET 8'h18
`define SLBT_A_INJ 8'h1c
`define SLBT_A_CHSEL 8'h20
`define SLBT_A_CHERR 8'h24
`define SLBT_A_CYC 8'h28
`define SLBT_A_TXW 8'h2c
`define SLBT_A_RXW 8'h30

// =============================================================
// Field positions and reset values
`define SLBT_CTRL_PORT_LSB 0
`define SLBT_CTRL_PAT_LSB 2
`define SLBT_CMD_START 0
`define SLBT_CMD_STOP 1
`define SLBT_CMD_INSERT 2
`define SLBT_CMD_CLEAR 3
`define SLBT_LOOP_RST 16'h0000
`define SLBT_CHSEL_RST 4'h0

`endif

// ### slbt_pkg.sv
// Types and the shared pattern stepping function of the lane tester.
// Assumes slbt_consts.svh is on the include path.
`include "slbt_consts.svh"

package slbt_pkg;

    typedef enum logic [2:0] {pat_prbs7, pat_prbs15, pat_prbs23,
        pat_prbs31, high_freq_pattern, low_freq_pattern} slbt_pat_t;
    typedef enum logic [1:0] {optical_port_zero, optical_port_one,
        pcie_x16} slbt_port_t;
    typedef enum logic {st_idle, st_run} slbt_run_t;
    typedef struct packed {
        logic [30:0] lfsr;
        logic [5:0] phase;
    } slbt_pst_t;

    // One word of pattern, bit 0 first on the line
    function automatic slbt_pst_t slbt_step(input slbt_pat_t p,
        input slbt_pst_t s, output logic [`SLBT_DW-1:0] w);
        slbt_pst_t n;
        logic b;
        n = s;
        w = '0;
        b = 1'b0;
        for (int i = 0; i < `SLBT_DW; i++) begin
            case (p)
                pat_prbs7: b = n.lfsr[6] ^ n.lfsr[5];
                pat_prbs15: b = n.lfsr[14] ^ n.lfsr[13];
                pat_prbs23: b = n.lfsr[22] ^ n.lfsr[17];
                high_freq_pattern: b = ~n.lfsr[0];
                low_freq_pattern: b = (n.phase < `SLBT_LF_HIGH);
                default: b = n.lfsr[30] ^ n.lfsr[27];
            endcase
            w[i] = b;
            n.lfsr = {n.lfsr[29:0], b};
            n.phase = (n.phase == `SLBT_LF_LAST) ? 6'd0 : n.phase + 6'd1;
        end
        return n;
    endfunction

endpackage

// ### slbt_lane_if.sv
// Per-channel bundle between the controller and its generator/checker.
// Assumes slbt_pkg is compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "slbt_consts.svh"

interface slbt_lane_if;
    import slbt_pkg::*;
    logic run;
    logic restart;
    slbt_pat_t pat;
    logic tx_adv;
    logic inject;
    logic inj_pend;
    logic [`SLBT_DW-1:0] tx_word;
    logic rx_vld;
    logic [`SLBT_DW-1:0] rx_word;
    logic synced;
    logic err;

    modport gen(input run, restart, pat, tx_adv, inject,
        output tx_word, inj_pend);
    modport chk(input run, restart, pat, rx_vld, rx_word,
        output synced, err);
endinterface

`default_nettype wire

// ### slbt_gen.sv
// Pattern generator for one channel, with one-word error injection.
// Assumes tx_adv means the presented word was taken by the serializer.
`timescale 1ns/10ps
`default_nettype none
`include "slbt_consts.svh"

module slbt_gen (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    slbt_lane_if.gen lane
);
    import slbt_pkg::*;

    slbt_pst_t st_q;
    slbt_pst_t st_d;
    logic [`SLBT_DW-1:0] w_d;
    logic [`SLBT_DW-1:0] word_q;
    logic pend_q;
    logic take;

    // =============================================================
    // Next pattern word
    always_comb begin
        st_d = slbt_step(lane.pat, st_q, w_d);
    end
    assign take = lane.run & lane.tx_adv;

    // Sequence state, reseeded at every start
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_q <= '{lfsr: `SLBT_SEED, phase: 6'd0};
        end else if (lane.restart) begin
            st_q <= '{lfsr: `SLBT_SEED, phase: 6'd0};
        end else if (take) begin
            st_q <= st_d;
        end
    end

    // Presented word; bit 0 flipped once when an error is pending
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            word_q <= '0;
        end else if (lane.restart || !lane.run) begin
            word_q <= '0;
        end else if (take) begin
            word_q <= w_d ^ {{(`SLBT_DW-1){1'b0}}, pend_q};
        end
    end

    // Pending injection; a new request in the consuming cycle survives
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pend_q <= 1'b0;
        end else begin
            pend_q <= lane.inject | (pend_q & ~take);
        end
    end

    assign lane.tx_word = word_q;
    assign lane.inj_pend = pend_q;
endmodule

`default_nettype wire

// ### slbt_chk.sv
// Pattern checker for one channel: self-seeding sync and error pulses.
// Assumes rx_word is the looped-back stream, bit 0 first.
`timescale 1ns/10ps
`default_nettype none
`include "slbt_consts.svh"

module slbt_chk (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    slbt_lane_if.chk lane
);
    import slbt_pkg::*;

    slbt_pst_t st_q;
    slbt_pst_t st_d;
    slbt_pst_t seed;
    logic [`SLBT_DW-1:0] exp_w;
    logic synced_q;
    logic err_q;
    logic take;
    logic match;

    // =============================================================
    // Expected word, and a reseed taken from the received bits
    always_comb begin
        st_d = slbt_step(lane.pat, st_q, exp_w);
        seed = st_d;
        seed.phase = (st_d.phase == `SLBT_LF_LAST) ? 6'd0 : st_d.phase + 6'd1;
        for (int k = 0; k < 31; k++) begin
            seed.lfsr[k] = lane.rx_word[`SLBT_DW-1-k];
        end
    end
    assign take = lane.run & lane.rx_vld & ~lane.restart;
    // An all-zero word never syncs, so a dead lane cannot look good
    assign match = (lane.rx_word == exp_w) && (lane.rx_word != '0);

    // Tracking state: reseed while hunting, free-run once locked on
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_q <= '{lfsr: `SLBT_SEED, phase: 6'd0};
        end else if (lane.restart) begin
            st_q <= '{lfsr: `SLBT_SEED, phase: 6'd0};
        end else if (take) begin
            st_q <= (synced_q || match) ? st_d : seed;
        end
    end

    // Sync flag: set on the first matching word after a start
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            synced_q <= 1'b0;
        end else if (lane.restart) begin
            synced_q <= 1'b0;
        end else if (take && match) begin
            synced_q <= 1'b1;
        end
    end

    // Error pulse per mismatching word, only once synced
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            err_q <= 1'b0;
        end else begin
            err_q <= take & synced_q & (lane.rx_word != exp_w);
        end
    end

    assign lane.synced = synced_q;
    assign lane.err = err_q;
endmodule

`default_nettype wire

// ### slbt_monitor.sv
// Checker of the lane tester's register port and loopback pins.
// Bound to slbt_top from the testbench; sees its ports only.
`timescale 1ns/10ps
`default_nettype none
`include "slbt_consts.svh"
module slbt_monitor (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire logic [`SLBT_NLANE-1:0] serial_loopback_out
);
    wire logic st = psel_in && !penable_in;
    wire logic lw = psel_in && penable_in && pwrite_in &&
        (paddr_in == 8'h0c || paddr_in == 8'h00);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    // ==========
    // Zero-wait answers, one cycle each
    property p_rdy; st |=> pready_out; endproperty
    a_rdy: assert property (p_rdy) else $error("late ready");
    property p_one; pready_out |-> $past(st); endproperty
    a_one: assert property (p_one) else $error("stray ready");
    property p_err; pslverr_out |-> pready_out; endproperty
    a_err: assert property (p_err) else $error("lone error");
    property p_idle; !pready_out |-> prdata_out == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("stale data");
    // Map edge: past the last word is refused
    property p_bad; st && paddr_in > 8'h30 |=> pslverr_out; endproperty
    a_bad: assert property (p_bad) else $error("no refusal");
    property p_ok; st && paddr_in <= 8'h30 && paddr_in[1:0] == 2'h0
        |=> !pslverr_out; endproperty
    a_ok: assert property (p_ok) else $error("false refusal");
    property p_cmd; st && !pwrite_in && paddr_in == 8'h04
        |=> prdata_out == 32'h0; endproperty
    a_cmd: assert property (p_cmd) else $error("command reads");
    // Loop pins move only on a loop or control write
    property p_lpb; !lw && !$past(lw)
        |=> $stable(serial_loopback_out); endproperty
    a_lpb: assert property (p_lpb) else $error("loop moved");
    c_bad: cover property (st ##1 pslverr_out);
    c_lpb: cover property (serial_loopback_out != '0);
    c_cmd: cover property (st && pwrite_in && paddr_in == 8'h04);
endmodule
`default_nettype wire

// ### slbt_loop_model.sv
// Far-side loop: returns each taken lane word as received data.
// Same clock as the tester; stall_in halves the word rate.
`timescale 1ns/10ps
`default_nettype none
module slbt_loop_model (
    input wire logic mclk_in,
    input wire logic stall_in,
    input wire logic [767:0] tx_in,
    output logic [23:0] rdy_out,
    output logic [23:0] vld_out,
    output logic [767:0] rx_out
);
    logic ph = 1'b0;
    assign rdy_out = {24{!stall_in || ph}};
    // Words come back a cycle late; idle data toggles, never stale
    always @(posedge mclk_in) begin
        ph <= ~ph;
        vld_out <= rdy_out;
        rx_out <= rdy_out[0] ? tx_in : ~rx_out;
    end
endmodule
`default_nettype wire

// ### tb_top.sv
// Testbench of the lane tester: register tasks and loopback runs.
// Assumes package, design, checker and far-side model are compiled.
`timescale 1ns/10ps
`default_nettype none
`include "slbt_consts.svh"
module tb_top;
    logic clk = 1'b0, rst_n = 1'b0, sel = 1'b0, en = 1'b0;
    logic wr = 1'b0, stall = 1'b0, rdy, err, er;
    logic [7:0] adr = 8'h0;
    logic [31:0] wd = 32'h0, prd, rd, w;
    logic [23:0] lock = 24'hffffff, txr, rxv, lpb;
    logic [767:0] txd, rxd;
    int mismatches = 0;
    int total_checks = 0;
    slbt_top dut_u (.mclk_in(clk), .rst_n_in(rst_n), .psel_in(sel),
        .penable_in(en), .pwrite_in(wr), .paddr_in(adr), .pwdata_in(wd),
        .prdata_out(prd), .pready_out(rdy), .pslverr_out(err),
        .pll_lock_in(lock), .tx_ready_in(txr), .tx_data_out(txd),
        .rx_valid_in(rxv), .rx_data_in(rxd), .serial_loopback_out(lpb));
    slbt_loop_model far_u (.mclk_in(clk), .stall_in(stall), .tx_in(txd),
        .rdy_out(txr), .vld_out(rxv), .rx_out(rxd));
    // ==========
    // Clock, bus tasks, verdict
    initial forever #2 clk = ~clk;
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic apb(input logic r, input logic [7:0] a,
        input logic [31:0] d);
        int j = 0;
        @(posedge clk);
        sel <= 1'b1;
        wr <= r;
        adr <= a;
        wd <= d;
        @(posedge clk);
        en <= 1'b1;
        do @(posedge clk); while (rdy !== 1'b1 && j++ < 20);
        if (rdy !== 1'b1) mismatches++;
        rd = prd;
        er = err;
        sel <= 1'b0;
        en <= 1'b0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        apb(0, a, 0);
        chk(rd, e);
    endtask
    task automatic cmd(input int b);
        apb(1, `SLBT_A_CMD, 32'h1 << b);
    endtask
    // Polls until every bit of e is set
    task automatic poll(input logic [7:0] a, input logic [31:0] e);
        int j = 0;
        do apb(0, a, 0); while ((rd & e) !== e && j++ < 60);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Hang guard, far beyond the few hundred cycles needed
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        complete_run;
    end
    // Test sequence
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        rc(`SLBT_A_CTRL, 0);
        rc(`SLBT_A_INJ, 0);
        rc(`SLBT_A_CMD, 0);
        rc(8'h40, 0);
        chk(32'(er), 1);
        apb(1, `SLBT_A_LOOP, 32'hf);
        repeat (2) @(posedge clk);
        chk(32'(lpb[3:0]), 32'hf);
        apb(1, `SLBT_A_LOOP, 0);
        $display("test regs done");
        for (int p = 0; p < 6; p++) begin
            cmd(`SLBT_CMD_CLEAR);
            apb(1, `SLBT_A_CTRL, p << 2);
            cmd(`SLBT_CMD_START);
            poll(`SLBT_A_STATUS, 4);
            rc(`SLBT_A_STATUS, 7);
            rc(`SLBT_A_DET, 0);
            w = txd[31:0];
            if (p == 4) chk(32'(w[30:0] ^ w[31:1]), 32'h7fffffff);
            if (p == 5) chk(32'($countones(w)) >> 1, 8);
            cmd(`SLBT_CMD_STOP);
            $display("test pattern %0d done", p);
        end
        cmd(`SLBT_CMD_INSERT);
        rc(`SLBT_A_INJ, 0);
        chk(txd[31:0], 0);
        apb(1, `SLBT_A_CTRL, 32'hc);
        cmd(`SLBT_CMD_CLEAR);
        cmd(`SLBT_CMD_START);
        poll(`SLBT_A_STATUS, 4);
        cmd(`SLBT_CMD_INSERT);
        rc(`SLBT_A_INJ, 1);
        poll(`SLBT_A_DET, 1);
        cmd(`SLBT_CMD_STOP);
        rc(`SLBT_A_DET, 1);
        rc(`SLBT_A_CHERR, 1);
        cmd(`SLBT_CMD_CLEAR);
        rc(`SLBT_A_DET, 0);
        rc(`SLBT_A_INJ, 0);
        $display("test insert done");
        stall <= 1'b1;
        apb(1, `SLBT_A_CTRL, 2);
        cmd(`SLBT_CMD_START);
        poll(`SLBT_A_STATUS, 4);
        rc(`SLBT_A_STATUS, 7);
        chk(32'(txd[255:0] == 0), 1);
        lock <= 24'hfffeff;
        rc(`SLBT_A_LOCK, 32'hfffe);
        rc(`SLBT_A_STATUS, 5);
        apb(0, `SLBT_A_TXW, 0);
        chk(32'(rd != 0), 1);
        $display("test pcie done");
        complete_run;
    end
endmodule
bind slbt_top slbt_monitor mon_u (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .paddr_in(paddr_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .serial_loopback_out(serial_loopback_out));
`default_nettype wire
